// file: src/lsr_pkg.sv
// Constants, field layouts and carrier types of the locked config bank
package lsr_pkg;

  // ****************************************************************
  // Geometry
  // ****************************************************************
  localparam int NUM_REGS = 4;
  localparam int NUM_FIELDS = 2;
  localparam int DATA_W = 32;
  localparam int ADDR_W = 6;
  localparam int IDX_W = 2;

  // ****************************************************************
  // Register map, byte addresses, one aligned word each
  // ****************************************************************
  localparam logic [ADDR_W-1:0] OFS_CFG_BASE = 6'h00;
  localparam logic [ADDR_W-1:0] OFS_LOCK_BASE = 6'h10;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 6'h20;
  localparam logic [ADDR_W-1:0] OFS_REFUSED = 6'h24;
  localparam logic [1:0] REGION_CFG = 2'h0;
  localparam logic [1:0] REGION_LOCK = 2'h1;
  localparam int REGION_LSB = 4;
  localparam int IDX_LSB = 2;

  // Status word bit positions
  localparam int STAT_HELD_BIT = 0;
  localparam int STAT_REQ_BIT = 1;

  // ****************************************************************
  // Field masks per register, used by field granular locking
  // ****************************************************************
  localparam logic [NUM_REGS-1:0][NUM_FIELDS-1:0][DATA_W-1:0]
    FIELD_MASK = '{
      '{32'hffff0000, 32'h0000ffff},
      '{32'hffffff00, 32'h000000ff},
      '{32'hff000000, 32'h00ffffff},
      '{32'hfffffff0, 32'h0000000f}
    };

  // ****************************************************************
  // Values after reset
  // ****************************************************************
  localparam logic [DATA_W-1:0] RDATA_RST = 32'h00000000;
  localparam logic [NUM_REGS-1:0] REFUSED_RST = 4'h0;
  localparam logic SYNC_RST = 1'h1;
  localparam logic STATUS_N_RST = 1'h0;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef logic [NUM_REGS-1:0][DATA_W-1:0] lsr_bank_t;

  // Programmed once; no run-time path alters these
  typedef struct packed {
    lsr_bank_t init_value;
    lsr_bank_t bit_lock;
    logic [NUM_REGS-1:0][NUM_FIELDS-1:0] field_lock;
    logic [NUM_REGS-1:0] reg_lock;
  } lsr_nv_cfg_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic wr;
    logic rd;
  } lsr_bus_req_t;

  typedef struct packed {
    lsr_bank_t cfg;
    logic [DATA_W-1:0] rdata;
    logic [NUM_REGS-1:0] refused;
    logic req_meta;
    logic req_sync;
    logic status_n;
  } lsr_state_t;

endpackage

// file: src/lsr_bank.sv
// Locked system configuration register bank with subsystem reset control
module lsr_bank (
  input wire logic mclk_in,
  input wire logic rst_in,
  input wire lsr_pkg::lsr_nv_cfg_t nv_cfg_in,
  input wire lsr_pkg::lsr_bus_req_t bus_in,
  input wire logic subsystem_reset_request_n_in,
  output logic [lsr_pkg::DATA_W-1:0] rdata_out,
  output lsr_pkg::lsr_bank_t config_out,
  output logic subsystem_reset_n_out,
  output logic subsystem_reset_status_n_out
);

  // ****************************************************************
  // State
  // ****************************************************************
  lsr_pkg::lsr_state_t state;
  lsr_pkg::lsr_state_t next_state;

  // Effective lock mask of each register, one bit per flop; a net,
  // since each generate pass drives its own word of it
  wire lsr_pkg::lsr_bank_t eff_lock;

  // Decoded bus fields
  logic [1:0] region;
  logic [lsr_pkg::IDX_W-1:0] idx;
  logic aligned;
  logic hit_cfg;
  logic hit_lock;
  logic hit_status;
  logic hit_refused;

  // ****************************************************************
  // Lock mask, merged from the three granularities
  // ****************************************************************
  // The non-volatile inputs are only ever read here and below; the
  // block offers no way to change them, so a lock cannot be undone
  // by software once the part is programmed.
  for (genvar g = 0; g < lsr_pkg::NUM_REGS; g++) begin : g_lock
    logic [lsr_pkg::DATA_W-1:0] field_part;

    // Expand field locks through the fixed field masks
    always_comb begin
      field_part = '0;
      for (int f = 0; f < lsr_pkg::NUM_FIELDS; f++) begin
        if (nv_cfg_in.field_lock[g][f]) begin
          field_part = field_part | lsr_pkg::FIELD_MASK[g][f];
        end
      end
    end

    // Register lock covers all bits, bit lock covers one each
    assign eff_lock[g] = nv_cfg_in.bit_lock[g]
                       | {lsr_pkg::DATA_W{nv_cfg_in.reg_lock[g]}}
                       | field_part;
  end

  // ****************************************************************
  // Address decode
  // ****************************************************************
  // Only aligned word addresses hit; anything else reads as zero and
  // a write to it is dropped without side effect.
  assign region = bus_in.addr[lsr_pkg::REGION_LSB +: 2];
  assign idx = bus_in.addr[lsr_pkg::IDX_LSB +: lsr_pkg::IDX_W];
  assign aligned = (bus_in.addr[1:0] == 2'h0);

  always_comb begin
    hit_cfg = 1'b0;
    hit_lock = 1'b0;
    hit_status = 1'b0;
    hit_refused = 1'b0;
    if (!aligned) begin
      hit_cfg = 1'b0;
    end else if (region == lsr_pkg::REGION_CFG) begin
      hit_cfg = 1'b1;
    end else if (region == lsr_pkg::REGION_LOCK) begin
      hit_lock = 1'b1;
    end else if (bus_in.addr == lsr_pkg::OFS_STATUS) begin
      hit_status = 1'b1;
    end else if (bus_in.addr == lsr_pkg::OFS_REFUSED) begin
      hit_refused = 1'b1;
    end
  end

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    logic held;
    logic wr_hit;
    logic [lsr_pkg::DATA_W-1:0] wr_val;
    logic [lsr_pkg::DATA_W-1:0] lock;
    logic [lsr_pkg::DATA_W-1:0] init;
    logic [lsr_pkg::NUM_REGS-1:0] refused_set;
    logic [lsr_pkg::NUM_REGS-1:0] refused_clr;

    held = 1'b0;
    wr_hit = 1'b0;
    wr_val = '0;
    lock = '0;
    init = '0;
    refused_set = '0;
    refused_clr = '0;
    next_state = state;

    // Two flops on the request pin; only the second one is used
    next_state.req_meta = subsystem_reset_request_n_in;
    next_state.req_sync = state.req_meta;

    // Subsystem is held while the synchronised request is low
    held = !state.req_sync;
    next_state.status_n = !held;

    // Per-register update with lock enforcement
    for (int r = 0; r < lsr_pkg::NUM_REGS; r++) begin
      lock = eff_lock[r];
      init = nv_cfg_in.init_value[r];
      wr_hit = bus_in.wr && hit_cfg && (idx == r[lsr_pkg::IDX_W-1:0]);
      wr_val = state.cfg[r];
      if (held) begin
        // Holding the subsystem also reloads its configuration
        wr_val = init;
      end else if (wr_hit) begin
        // Unlocked bits take the written data
        wr_val = (state.cfg[r] & lock)
               | (bus_in.wdata & ~lock);
        // Note an attempt to change a protected bit
        if (((bus_in.wdata ^ state.cfg[r]) & lock) != '0) begin
          refused_set[r] = 1'b1;
        end
      end
      // Locked flops are forced back to init every edge, which also
      // undoes any upset; the repair lands on the next clock, not
      // asynchronously, since this block has no async reset path.
      next_state.cfg[r] = (wr_val & ~lock) | (init & lock);
    end

    // Write one clears refused flags; a new refusal wins the clear
    if (bus_in.wr && hit_refused) begin
      refused_clr = bus_in.wdata[lsr_pkg::NUM_REGS-1:0];
    end
    next_state.refused = (state.refused & ~refused_clr)
                       | refused_set;

    // Read data stands for one cycle only, zero otherwise
    next_state.rdata = '0;
    if (bus_in.rd) begin
      if (hit_cfg) begin
        next_state.rdata = state.cfg[idx];
      end else if (hit_lock) begin
        next_state.rdata = eff_lock[idx];
      end else if (hit_status) begin
        next_state.rdata[lsr_pkg::STAT_HELD_BIT] = !state.status_n;
        next_state.rdata[lsr_pkg::STAT_REQ_BIT] = state.req_sync;
      end else if (hit_refused) begin
        next_state.rdata[lsr_pkg::NUM_REGS-1:0] = state.refused;
      end
    end

    // Synchronous reset: the bank loads its programmed values
    if (rst_in) begin
      next_state.cfg = nv_cfg_in.init_value;
      next_state.rdata = lsr_pkg::RDATA_RST;
      next_state.refused = lsr_pkg::REFUSED_RST;
      next_state.req_meta = lsr_pkg::SYNC_RST;
      next_state.req_sync = lsr_pkg::SYNC_RST;
      next_state.status_n = lsr_pkg::STATUS_N_RST;
    end
  end

  // ****************************************************************
  // State register
  // ****************************************************************
  always_ff @(posedge mclk_in) begin
    state <= next_state;
  end

  // ****************************************************************
  // Outputs, all straight from flops
  // ****************************************************************
  // Fabric readers reach rdata through their interface controller
  assign rdata_out = state.rdata;
  assign config_out = state.cfg;
  assign subsystem_reset_n_out = state.status_n;
  assign subsystem_reset_status_n_out = state.status_n;

endmodule

// file: verif/lsr_bank_monitor.sv
// Port checker for the locked config bank
module lsr_bank_monitor (
  input wire logic mclk_in,
  input wire logic rst_in,
  input wire lsr_pkg::lsr_nv_cfg_t nv_cfg_in,
  input wire lsr_pkg::lsr_bus_req_t bus_in,
  input wire logic subsystem_reset_request_n_in,
  input wire logic [31:0] rdata_out,
  input wire lsr_pkg::lsr_bank_t config_out,
  input wire logic subsystem_reset_n_out,
  input wire logic subsystem_reset_status_n_out
);
  default clocking @(posedge mclk_in); endclocking
  default disable iff (rst_in);
  logic [1:0] wi;
  logic [31:0] wx;
  // Lock mask of one register over all three granularities
  function automatic logic [31:0] lk(input logic [1:0] r);
    lk = nv_cfg_in.bit_lock[r] | {32{nv_cfg_in.reg_lock[r]}};
    for (int f = 0; f < 2; f++) begin
      if (nv_cfg_in.field_lock[r][f]) begin
        lk = lk | lsr_pkg::FIELD_MASK[r][f];
      end
    end
  endfunction
  // Expected word after a write, kept for the next edge
  always_ff @(posedge mclk_in) begin
    wi <= bus_in.addr[3:2];
    wx <= (bus_in.wdata & ~lk(bus_in.addr[3:2]))
      | (nv_cfg_in.init_value[bus_in.addr[3:2]] & lk(bus_in.addr[3:2]));
  end
  sequence s_wr;
    bus_in.wr && bus_in.addr[5:4] == 2'h0 && bus_in.addr[1:0] == 2'h0;
  endsequence
  sequence s_rd;
    bus_in.rd && bus_in.addr[5:4] == 2'h0 && bus_in.addr[1:0] == 2'h0;
  endsequence
  // A write only misses while the subsystem is held
  a_write_lands: assert property (s_wr |=>
    !subsystem_reset_status_n_out || config_out[wi] == wx)
    else $error("write result wrong");
  a_locked_stay: assert property (((config_out ^ nv_cfg_in.init_value)
    & {lk(2'h3), lk(2'h2), lk(2'h1), lk(2'h0)}) == '0)
    else $error("locked bit moved");
  a_reset_load: assert property ($fell(rst_in) |->
    config_out == nv_cfg_in.init_value) else $error("bad load");
  a_read_word: assert property (s_rd |=>
    rdata_out == $past(config_out[bus_in.addr[3:2]]))
    else $error("read data wrong");
  a_read_quiet: assert property (!bus_in.rd |=> rdata_out == '0)
    else $error("stray read data");
  a_hold_enter: assert property (!subsystem_reset_request_n_in
    |-> ##3 !subsystem_reset_status_n_out) else $error("no hold");
  a_hold_leave: assert property (subsystem_reset_request_n_in
    |-> ##3 subsystem_reset_status_n_out) else $error("no leave");
  a_status_pair: assert property (subsystem_reset_status_n_out
    == subsystem_reset_n_out) else $error("status differs");
  a_held_init: assert property (!subsystem_reset_status_n_out
    |-> config_out == nv_cfg_in.init_value) else $error("not forced");
endmodule

bind lsr_bank lsr_bank_monitor lsr_bank_monitor_inst (.mclk_in,
  .rst_in, .nv_cfg_in, .bus_in, .subsystem_reset_request_n_in,
  .rdata_out, .config_out, .subsystem_reset_n_out,
  .subsystem_reset_status_n_out);

// file: verif/lsr_fabric_model.sv
// Fabric logic model: drives the hold request, polls status
module lsr_fabric_model (
  input wire logic mclk_in,
  input wire logic hold_cmd_in,
  input wire logic status_n_in,
  output logic request_n_out,
  output logic held_out
);
  // Level request, moved only just after an edge
  initial request_n_out = 1'b1;
  always @(posedge mclk_in) begin
    request_n_out <= !hold_cmd_in;
  end
  // Polled confirmation that the subsystem sits in reset
  assign held_out = !status_n_in;
endmodule

// file: verif/lsr_bank_tb_top.sv
// Testbench for the locked config bank
module lsr_bank_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam lsr_pkg::lsr_bank_t IV = {32'h13579bdf, 32'h2468ace0,
    32'hc3a5965a, 32'h0ff01234};
  localparam lsr_pkg::lsr_bank_t LK = {32'h0, 32'hffffffff,
    lsr_pkg::FIELD_MASK[1][0], 32'h0000ff00};
  logic mclk_in = 1'b0;
  logic rst_in = 1'b1;
  logic hold = 1'b0;
  logic req_n, held, rst_n, stat_n;
  logic [31:0] rdata;
  lsr_pkg::lsr_bank_t cfg;
  // Bit lock on reg 0, field lock on reg 1, whole lock on reg 2
  lsr_pkg::lsr_nv_cfg_t nv = '{IV, 128'h0000ff00, 8'h04, 4'h4};
  lsr_pkg::lsr_bus_req_t bus = '0;
  int miscompares = 0;
  int tests_run = 0;
  always #12.5 mclk_in = ~mclk_in;
  lsr_bank lsr_bank_inst (.mclk_in, .rst_in, .nv_cfg_in(nv),
    .bus_in(bus), .subsystem_reset_request_n_in(req_n),
    .rdata_out(rdata), .config_out(cfg), .subsystem_reset_n_out(rst_n),
    .subsystem_reset_status_n_out(stat_n));
  lsr_fabric_model lsr_fabric_model_inst (.mclk_in, .hold_cmd_in(hold),
    .status_n_in(stat_n), .request_n_out(req_n), .held_out(held));
  task automatic chk(input string n, input logic [31:0] s, e);
    tests_run++;
    if (s !== e) begin
      miscompares++;
      $display("BAD %s exp %h got %h", n, e, s);
    end
  endtask
  // Bus cycles; reads sample the single cycle of valid data
  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    @(posedge mclk_in);
    bus <= '{a, d, 1'b1, 1'b0};
    @(posedge mclk_in);
    bus.wr <= 1'b0;
  endtask
  // Fabric side reads as through its enabled interface controller
  task automatic rd(input logic [5:0] a, input logic [31:0] e);
    @(posedge mclk_in);
    bus <= '{a, 32'h0, 1'b0, 1'b1};
    @(posedge mclk_in);
    bus.rd <= 1'b0;
    #1 chk("rdata", rdata, e);
  endtask
  // Bounded wait for the polled hold state
  task automatic wt(input logic v);
    int n = 0;
    while (held !== v && n < 20) begin
      @(posedge mclk_in);
      #1 n++;
    end
    chk("held", {31'h0, held}, {31'h0, v});
  endtask
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  initial begin
    repeat (4) @(posedge mclk_in);
    rst_in <= 1'b0;
    for (int r = 0; r < 4; r++) rd(6'(4 * r), IV[r]);
    rd(6'h18, 32'hffffffff);
    $display("test powerup done");
    // Inverse of every initial value: only unlocked bits may move
    for (int r = 0; r < 4; r++) wr(6'(4 * r), ~IV[r]);
    for (int r = 0; r < 4; r++) rd(6'(4 * r), IV[r] ^ ~LK[r]);
    rd(6'h24, 32'h7);
    wr(6'h24, 32'hf);
    rd(6'h24, 32'h0);
    rd(6'h28, 32'h0);
    $display("test locks done");
    // Fabric holds the subsystem, then lets it go
    @(posedge mclk_in);
    hold <= 1'b1;
    wt(1'b1);
    rd(6'h20, 32'h1);
    chk("cfg3", cfg[3], IV[3]);
    wr(6'h0c, 32'h0);
    rd(6'h0c, IV[3]);
    @(posedge mclk_in);
    hold <= 1'b0;
    wt(1'b0);
    rd(6'h20, 32'h2);
    $display("test hold done");
    print_verdict();
  end
  // Watchdog well beyond the few dozen cycles the tests need
  initial begin
    repeat (3000) @(posedge mclk_in);
    miscompares++;
    print_verdict();
  end
endmodule
